// ===== hdl/cce_pkg.sv
// Package for the command execution sequencer: register map, status codes and run window timing.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
package cce_pkg;

	// ****************************************
	// Clock and run window timing
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int RUN_BASE_US = 62500;
	localparam int RUN_STEP_US = 250000;
	localparam int RUN_BASE_CYC = RUN_BASE_US * (CLK_HZ / 1000000);
	localparam int RUN_STEP_CYC = RUN_STEP_US * (CLK_HZ / 1000000);

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [4:0] OFS_CMD = 5'h00;
	localparam logic [4:0] OFS_RUN_TIME = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_HDR_DATA = 5'h0C;
	localparam logic [4:0] OFS_PRD_DATA = 5'h10;
	localparam logic [4:0] OFS_HDR_CRC = 5'h14;
	localparam logic [4:0] OFS_PRD_CRC = 5'h18;
	localparam logic [4:0] OFS_COUNTS = 5'h1C;

	// ****************************************
	// Command codes written to the command register
	// ****************************************
	localparam logic [2:0] CMD_SELECT = 3'h1;
	localparam logic [2:0] CMD_START = 3'h2;
	localparam logic [2:0] CMD_CONTINUE = 3'h3;

	// ****************************************
	// Fields, sizes and reset values
	// ****************************************
	localparam int HDR_BYTES = 8;
	localparam int PRD_BYTES = 128;
	localparam int HDR_LEN_IDX = 1;
	localparam int BUSY_BIT = 5;
	localparam int RUN_CODE_W = 4;
	localparam logic [7:0] ST_RESET = 8'h00;
	localparam logic [7:0] ST_BUSY = 8'h20;
	localparam logic [7:0] ST_HDR_SIZE = 8'h05;
	localparam logic [7:0] ST_DATA_SIZE = 8'h06;
	localparam logic [7:0] ST_NO_HEADER = 8'h0D;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_INIT = 16'h0000;

endpackage

// ===== hdl/cce_run_timer.sv
// Run window timer: counts the window chosen by the 4-bit run time code and flags its end.
// Assumes start and abort are single-cycle pulses from the sequencer in the same clock domain.
`timescale 1ns/10ps
module cce_run_timer
	import cce_pkg::*;
#(
	parameter int BASE_CYC = RUN_BASE_CYC,
	parameter int STEP_CYC = RUN_STEP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [RUN_CODE_W-1:0] code,
	// Status
	output logic active,
	output logic alarm
);

	logic [31:0] cnt_r;
	logic active_r;
	logic alarm_r;
	logic [31:0] load_val;

	// Window = code * step + base
	assign load_val = 32'(code) * 32'(STEP_CYC) + 32'(BASE_CYC); // [R13]

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 32'h0;
			active_r <= 1'b0;
			alarm_r <= 1'b0;
		end else begin
			alarm_r <= 1'b0;
			if (abort) begin
				active_r <= 1'b0;
				cnt_r <= 32'h0;
			end else if (start) begin
				active_r <= 1'b1;
				cnt_r <= load_val - 32'h1;
			end else if (active_r) begin
				if (cnt_r == 32'h0) begin
					// Alarm stops the micro before the host can return
					active_r <= 1'b0;
					alarm_r <= 1'b1; // [R14]
				end else begin
					cnt_r <= cnt_r - 32'h1;
				end
			end
		end
	end

	assign active = active_r;
	assign alarm = alarm_r;

endmodule

// ===== hdl/cce_sequencer.sv
// Command execution sequencer: header buffer, product data register, run time and status registers.
// Assumes an Avalon-MM master on the register bus and a firmware core on the FW_ ports.
//
// Functional notes
// R1 - Host addresses the device afresh before every buffer, register or command operation.
// R2 - Launch: header, then payload, then run time code, then first-run command.
// R3 - After a run command host powers the line for the window, then reads status.
// R4 - Command complete when micro status bit 5 is zero; else continue-run again.
// R5 - When complete host reads result header, then result payload, then bus reset.
// R6 - Input blocks 1 to N-1 each sent with minimum run time and first-run.
// R7 - Host stops reading result blocks when block number top bit is one.
// R8 - Host checks status before a new command and finishes incomplete ones.
// R9 - With accelerator state nonzero host waits a fixed 3812.5 ms.
// R10 - Output of an interrupted command completed later is discarded, never readable.
// R11 - Device returns CRC16 once header bytes written reach the header length.
// R12 - Device returns CRC16 of product register data written.
// R13 - Only low 4 run time bits count; window is code*250 ms plus 62.5 ms.
// R14 - Internal timer alarms at window end so the micro stops work safely.
// R15 - Host must not communicate while the micro runs; that interrupts the work.
// R16 - Run time register is written before any execution cycle begins.
// R17 - Header buffer holds only the block header; payload goes through product register.
// R18 - Long computations need several power cycles; host loops until done.
// R19 - Transfer condition codes sit in the low 6 bits of micro status.
// R20 - Header is eight bytes; payload block holds 1 to 128 bytes.
// R21 - Block numbers count from 0; last block has top bit set.
// R22 - Host times each power window from the run time code.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module cce_sequencer
	import cce_pkg::*;
#(
	parameter int BASE_CYC = RUN_BASE_CYC,
	parameter int STEP_CYC = RUN_STEP_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Avalon-MM slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Firmware core
	input wire logic FW_WR,
	input wire logic FW_SEL_PRD,
	input wire logic [6:0] FW_ADDR,
	input wire logic [7:0] FW_DATA,
	input wire logic [7:0] FW_STATUS,
	input wire logic [7:0] ACCEL_STATE,
	output logic MCU_RUN,
	output logic MCU_ALARM
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] hdr_mem [HDR_BYTES];
	logic [7:0] prd_mem [PRD_BYTES];
	logic [3:0] hdr_cnt_r;
	logic [7:0] prd_cnt_r;
	logic [3:0] hdr_rd_r;
	logic [7:0] prd_rd_r;
	logic hdr_fresh_r;
	logic prd_fresh_r;
	logic [15:0] hdr_crc_r;
	logic [15:0] prd_crc_r;
	logic [RUN_CODE_W-1:0] run_time_r;
	logic [7:0] micro_status_r;
	logic [7:0] accelerator_state_r;
	logic interrupted_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic acc_wr;
	logic acc_rd;
	logic launch;
	logic run_start;
	logic run_abort;
	logic run_active;
	logic run_alarm;
	logic mcu_run_r;
	logic mcu_alarm_r;
	logic discard;

	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] din);
		logic [15:0] c;
		c = crc ^ {8'h00, din};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic is_reg(input logic [4:0] addr, input logic [4:0] ofs);
		return addr[4:2] == ofs[4:2];
	endfunction

	// ****************************************
	// Bus handshake
	// ****************************************
	// Every request is answered one cycle after it appears; waitrequest is low for that one edge
	always_ff @(posedge CLK) begin
		if (RST) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !((AVS_READ || AVS_WRITE) && wait_r);
		end
	end

	assign acc_wr = AVS_WRITE && !wait_r;
	assign acc_rd = AVS_READ && !wait_r;
	assign launch = acc_wr && is_reg(AVS_ADDRESS, OFS_CMD) && AVS_BYTEENABLE[0]
		&& (AVS_WRITEDATA[2:0] == CMD_START || AVS_WRITEDATA[2:0] == CMD_CONTINUE);
	// A start is refused when header or payload sizes do not match
	assign run_start = launch && !(AVS_WRITEDATA[2:0] == CMD_START
		&& (hdr_cnt_r != 4'(HDR_BYTES) || prd_cnt_r != hdr_mem[HDR_LEN_IDX])); // [R20]
	// Bus traffic while the micro runs is a power failure to it
	assign run_abort = mcu_run_r && (acc_wr || acc_rd); // [R15]
	assign discard = run_alarm && !FW_STATUS[BUSY_BIT] && interrupted_r; // [R10]

	cce_run_timer #(
		.BASE_CYC(BASE_CYC),
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.start(run_start),
		.abort(run_abort),
		.code(run_time_r),
		.active(run_active),
		.alarm(run_alarm)
	);

	// ****************************************
	// Run time, status and micro control
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			run_time_r <= '0;
		end else if (acc_wr && is_reg(AVS_ADDRESS, OFS_RUN_TIME) && AVS_BYTEENABLE[0]) begin
			run_time_r <= AVS_WRITEDATA[RUN_CODE_W-1:0]; // [R13] [R16]
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			micro_status_r <= ST_RESET;
			accelerator_state_r <= 8'h00;
			interrupted_r <= 1'b0;
		end else begin
			accelerator_state_r <= ACCEL_STATE;
			if (run_abort) begin
				interrupted_r <= 1'b1;
			end else if (discard) begin
				interrupted_r <= 1'b0;
			end
			if (run_alarm) begin
				micro_status_r <= FW_STATUS; // [R19]
			end else if (launch && !run_start) begin
				micro_status_r <= (hdr_cnt_r == 4'h0) ? ST_NO_HEADER :
					(hdr_cnt_r != 4'(HDR_BYTES)) ? ST_HDR_SIZE : ST_DATA_SIZE;
			end else if (run_start) begin
				// Busy until the firmware reports otherwise at window end
				micro_status_r <= ST_BUSY; // [R4]
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			mcu_run_r <= 1'b0;
			mcu_alarm_r <= 1'b0;
		end else begin
			mcu_run_r <= run_active && !run_abort;
			mcu_alarm_r <= run_alarm; // [R14]
		end
	end

	// ****************************************
	// Header buffer and product data register
	// ****************************************
	// Header and payload are kept apart; each has its own CRC
	always_ff @(posedge CLK) begin
		if (RST) begin
			hdr_cnt_r <= 4'h0;
			prd_cnt_r <= 8'h00;
			hdr_fresh_r <= 1'b1;
			prd_fresh_r <= 1'b1;
			hdr_crc_r <= CRC_INIT;
			prd_crc_r <= CRC_INIT;
		end else if (discard) begin
			hdr_cnt_r <= 4'h0; // [R10]
			prd_cnt_r <= 8'h00;
			hdr_fresh_r <= 1'b1;
			prd_fresh_r <= 1'b1;
		end else if (FW_WR) begin
			if (FW_SEL_PRD) begin
				prd_mem[FW_ADDR] <= FW_DATA;
				prd_cnt_r <= {1'b0, FW_ADDR} + 8'h01;
			end else begin
				hdr_mem[FW_ADDR[2:0]] <= FW_DATA;
				hdr_cnt_r <= {1'b0, FW_ADDR[2:0]} + 4'h1;
			end
		end else if (acc_wr && AVS_BYTEENABLE[0] && !mcu_run_r) begin
			if (is_reg(AVS_ADDRESS, OFS_HDR_DATA) && (hdr_fresh_r || hdr_cnt_r < 4'(HDR_BYTES))) begin
				// A fresh block always lands at byte 0, where the block number sits
				hdr_mem[hdr_fresh_r ? 3'h0 : hdr_cnt_r[2:0]] <= AVS_WRITEDATA[7:0]; // [R17] [R21]
				hdr_cnt_r <= hdr_fresh_r ? 4'h1 : hdr_cnt_r + 4'h1;
				hdr_crc_r <= crc16_byte(hdr_fresh_r ? CRC_INIT : hdr_crc_r, AVS_WRITEDATA[7:0]); // [R11]
				hdr_fresh_r <= 1'b0;
			end else if (is_reg(AVS_ADDRESS, OFS_PRD_DATA)
				&& (prd_fresh_r || prd_cnt_r < 8'(PRD_BYTES))) begin
				prd_mem[prd_fresh_r ? 7'h00 : prd_cnt_r[6:0]] <= AVS_WRITEDATA[7:0]; // [R17]
				prd_cnt_r <= prd_fresh_r ? 8'h01 : prd_cnt_r + 8'h01;
				prd_crc_r <= crc16_byte(prd_fresh_r ? CRC_INIT : prd_crc_r, AVS_WRITEDATA[7:0]); // [R12]
				prd_fresh_r <= 1'b0;
			end else if (is_reg(AVS_ADDRESS, OFS_CMD) && (AVS_WRITEDATA[2:0] == CMD_SELECT || launch)) begin
				// A new access or run lets the next write open a new block
				hdr_fresh_r <= 1'b1; // [R1]
				prd_fresh_r <= 1'b1;
			end
		end
	end

	// Read pointers rewind on every device selection and run
	always_ff @(posedge CLK) begin
		if (RST) begin
			hdr_rd_r <= 4'h0;
			prd_rd_r <= 8'h00;
		end else if (acc_wr && is_reg(AVS_ADDRESS, OFS_CMD)) begin
			hdr_rd_r <= 4'h0; // [R1]
			prd_rd_r <= 8'h00;
		end else if (acc_rd && !mcu_run_r) begin
			if (is_reg(AVS_ADDRESS, OFS_HDR_DATA) && hdr_rd_r < hdr_cnt_r) begin
				hdr_rd_r <= hdr_rd_r + 4'h1; // [R5]
			end
			if (is_reg(AVS_ADDRESS, OFS_PRD_DATA) && prd_rd_r < prd_cnt_r) begin
				prd_rd_r <= prd_rd_r + 8'h01;
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rdata_nxt = 32'h0;
		case (AVS_ADDRESS[4:2])
			OFS_CMD[4:2]: rdata_nxt = 32'h0;
			OFS_RUN_TIME[4:2]: rdata_nxt = {28'h0, run_time_r};
			OFS_STATUS[4:2]: rdata_nxt = {14'h0, interrupted_r, mcu_run_r, accelerator_state_r, micro_status_r}; // [R19]
			OFS_HDR_DATA[4:2]: rdata_nxt = (hdr_rd_r < hdr_cnt_r) ? {24'h0, hdr_mem[hdr_rd_r[2:0]]} : 32'h0;
			OFS_PRD_DATA[4:2]: rdata_nxt = (prd_rd_r < prd_cnt_r) ? {24'h0, prd_mem[prd_rd_r[6:0]]} : 32'h0;
			// CRC valid once the written header reaches its length
			OFS_HDR_CRC[4:2]: rdata_nxt = {15'h0, !hdr_fresh_r && hdr_cnt_r == 4'(HDR_BYTES), hdr_crc_r}; // [R11]
			OFS_PRD_CRC[4:2]: rdata_nxt = {15'h0, !prd_fresh_r, prd_crc_r}; // [R12]
			OFS_COUNTS[4:2]: rdata_nxt = {16'h0, prd_cnt_r, 4'h0, hdr_cnt_r};
			default: rdata_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_r <= 32'h0;
		end else if (AVS_READ && wait_r) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign AVS_READDATA = rdata_r;
	assign AVS_WAITREQUEST = wait_r;
	assign MCU_RUN = mcu_run_r;
	assign MCU_ALARM = mcu_alarm_r;

endmodule

// ===== verification/cce_fw_model.sv
// Firmware core model: busy for the first windows, then loads a one-block result.
// Assumes run and alarm come from the sequencer in the same clock domain.
`timescale 1ns/10ps
module cce_fw_model
	import cce_pkg::*;
#(
	parameter int NEED = 2,
	parameter logic [7:0] ACC = 8'h5A
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// From sequencer
	input wire logic run,
	input wire logic alarm,
	// Firmware side
	output logic fw_wr,
	output logic fw_sel_prd,
	output logic [6:0] fw_addr,
	output logic [7:0] fw_data,
	output logic [7:0] fw_status,
	output logic [7:0] accel_state
);
	int runs;
	int idx;
	logic last;
	assign last = (runs + 1 >= NEED);
	// Incomplete code keeps bit 5 set until the final window
	assign fw_status = last ? 8'h00 : 8'h21;
	assign accel_state = ACC;
	always_ff @(posedge clk) begin
		fw_wr <= 1'b0;
		// Idle data toggles so a stale byte is never mistaken for a load
		fw_data <= ~fw_data;
		if (rst) begin
			runs <= 0;
			idx <= 0;
			fw_data <= 8'h00;
			fw_sel_prd <= 1'b0;
			fw_addr <= 7'h00;
		end else begin
			if (alarm)
				runs <= runs + 1;
			if (run && last && idx < 12) begin
				fw_wr <= 1'b1;
				fw_sel_prd <= (idx >= 8);
				fw_addr <= 7'(idx < 8 ? idx : idx - 8);
				fw_data <= idx == 0 ? 8'h80 : idx == 1 ? 8'h04 : 8'(8'hA0 + idx);
				idx <= idx + 1;
			end
		end
	end
endmodule

// ===== verification/cce_seq_chk.sv
// Checker for the sequencer: bus handshake and run window timing.
// Assumes it is bound to cce_sequencer and sees only its ports.
`timescale 1ns/10ps
module cce_seq_chk
	import cce_pkg::*;
#(
	parameter int BASE_CYC = RUN_BASE_CYC,
	parameter int STEP_CYC = RUN_STEP_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register bus
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic AVS_WAITREQUEST,
	// Run window
	input wire logic MCU_RUN,
	input wire logic MCU_ALARM
);
	logic [31:0] run_cnt_r;
	logic req;
	logic cont_wr;
	assign req = AVS_READ | AVS_WRITE;
	assign cont_wr = AVS_WRITE & !AVS_WAITREQUEST & AVS_BYTEENABLE[0] & (AVS_ADDRESS[4:2] == 3'h0);
	// Counts the open cycles so far; the longest window is code 15
	always_ff @(posedge CLK) begin
		run_cnt_r <= (RST | !MCU_RUN) ? 32'h0 : run_cnt_r + 32'h1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_wait_one; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	property p_wait_pulse; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	property p_idle_wait; !req |-> AVS_WAITREQUEST; endproperty
	property p_run_len; MCU_RUN |-> run_cnt_r < 32'(15 * STEP_CYC + BASE_CYC); endproperty
	property p_cont_run; cont_wr && AVS_WRITEDATA[2:0] == CMD_CONTINUE && !MCU_RUN |-> ##[1:2] MCU_RUN; endproperty
	property p_run_cause; $rose(MCU_RUN) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2); endproperty
	property p_alarm_cause; MCU_ALARM |-> !MCU_RUN && ($past(MCU_RUN) || $past(MCU_RUN, 2)); endproperty
	property p_alarm_one; MCU_ALARM |=> !MCU_ALARM; endproperty
	property p_run_abort; MCU_RUN && req && !AVS_WAITREQUEST |=> !MCU_RUN; endproperty
	a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait");
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low without request");
	a_run_len: assert property (p_run_len) else $error("run window too long");
	a_cont_run: assert property (p_cont_run) else $error("continue did not open window");
	a_run_cause: assert property (p_run_cause) else $error("window opened without command");
	a_alarm_cause: assert property (p_alarm_cause) else $error("alarm outside window end");
	a_alarm_one: assert property (p_alarm_one) else $error("alarm longer than one cycle");
	a_run_abort: assert property (p_run_abort) else $error("bus access did not end the window");
	c_run: cover property ($rose(MCU_RUN));
	c_alarm: cover property (MCU_ALARM);
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
	c_abort: cover property ($fell(MCU_RUN) && !MCU_ALARM);
endmodule
bind cce_sequencer cce_seq_chk #(.BASE_CYC(BASE_CYC), .STEP_CYC(STEP_CYC)) cce_seq_chk_i (.CLK(CLK), .RST(RST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MCU_RUN(MCU_RUN), .MCU_ALARM(MCU_ALARM));

// ===== verification/tb_coprocessor_command_exec_sequencer.sv
// Testbench for the command sequencer with a firmware core model.
// Assumes short window parameters so a full command takes a few hundred cycles.
`timescale 1ns/10ps
module tb_coprocessor_command_exec_sequencer
	import cce_pkg::*;
();
	localparam int BASE = 10;
	localparam int STEP = 40;
	localparam logic [7:0] ACC = 8'h5A;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA, rd;
	logic AVS_WAITREQUEST, FW_WR, FW_SEL_PRD, MCU_RUN, MCU_ALARM;
	logic [6:0] FW_ADDR;
	logic [7:0] FW_DATA, FW_STATUS, ACCEL_STATE;
	int err_count = 0;
	int check_count = 0;
	always #50 CLK = ~CLK;
	cce_sequencer #(.BASE_CYC(BASE), .STEP_CYC(STEP)) cce_sequencer_i (.CLK(CLK), .RST(RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.FW_WR(FW_WR), .FW_SEL_PRD(FW_SEL_PRD), .FW_ADDR(FW_ADDR), .FW_DATA(FW_DATA), .FW_STATUS(FW_STATUS),
		.ACCEL_STATE(ACCEL_STATE), .MCU_RUN(MCU_RUN), .MCU_ALARM(MCU_ALARM));
	cce_fw_model #(.NEED(2), .ACC(ACC)) cce_fw_model_i (.clk(CLK), .rst(RST), .run(MCU_RUN), .alarm(MCU_ALARM),
		.fw_wr(FW_WR), .fw_sel_prd(FW_SEL_PRD), .fw_addr(FW_ADDR), .fw_data(FW_DATA), .fw_status(FW_STATUS),
		.accel_state(ACCEL_STATE));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (n >= 20)
			check(32'h1, 32'h0);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(rd, exp);
	endtask
	// Counts open cycles up to the alarm; no bus access, which would abort the window
	task automatic window(input int code);
		int n;
		int k;
		n = 0;
		k = 0;
		while (MCU_ALARM !== 1'b1 && k < 2000) begin
			@(posedge CLK);
			k++;
			n += (MCU_RUN === 1'b1);
		end
		check(n, code * STEP + BASE);
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	// Block number bn and length byte len go into the header; np payload bytes follow
	task automatic send(input logic [7:0] bn, input logic [7:0] len, input int np);
		logic [15:0] hc;
		logic [15:0] pc;
		logic [7:0] b;
		hc = CRC_INIT;
		pc = CRC_INIT;
		for (int i = 0; i < 8; i++) begin
			b = i == 0 ? bn : i == 1 ? len : 8'(i);
			wr(OFS_HDR_DATA, b);
			hc = crc(hc, b);
		end
		rdchk(OFS_HDR_CRC, {15'h0, 1'b1, hc});
		for (int i = 0; i < np; i++) begin
			b = 8'hC0 + 8'(i);
			wr(OFS_PRD_DATA, b);
			pc = crc(pc, b);
		end
		rdchk(OFS_PRD_CRC, {15'h0, 1'b1, pc});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdchk(OFS_STATUS, {16'h0, ACC, ST_RESET});
		rdchk(OFS_COUNTS, 32'h0);
		rdchk(OFS_RUN_TIME, 32'h0);
	endtask
	task automatic t_refuse();
		wr(OFS_CMD, CMD_SELECT);
		wr(OFS_CMD, CMD_START);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_NO_HEADER});
		wr(OFS_CMD, CMD_SELECT);
		for (int i = 0; i < 5; i++)
			wr(OFS_HDR_DATA, 8'h04);
		wr(OFS_CMD, CMD_START);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_HDR_SIZE});
		wr(OFS_CMD, CMD_SELECT);
		send(8'h80, 8'h04, 3);
		wr(OFS_CMD, CMD_START);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_DATA_SIZE});
	endtask
	task automatic t_cmd();
		wr(OFS_CMD, CMD_SELECT);
		send(8'h80, 8'h04, 4);
		rdchk(OFS_COUNTS, 32'h0408);
		wr(OFS_RUN_TIME, 8'hF1);
		rdchk(OFS_RUN_TIME, 32'h1);
		wr(OFS_CMD, CMD_START);
		window(1);
		rdchk(OFS_STATUS, {16'h0, ACC, 8'h21});
		wr(OFS_RUN_TIME, 8'h02);
		wr(OFS_CMD, CMD_CONTINUE);
		window(2);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_RESET});
		wr(OFS_CMD, CMD_SELECT);
		for (int i = 0; i < 8; i++)
			rdchk(OFS_HDR_DATA, i == 0 ? 32'h80 : i == 1 ? 32'h4 : 32'hA0 + i);
		for (int i = 8; i < 12; i++)
			rdchk(OFS_PRD_DATA, 32'hA0 + i);
	endtask
	// A status read inside the window aborts it; the next finished run drops the stale result
	task automatic t_interrupt();
		wr(OFS_CMD, CMD_SELECT);
		send(8'h80, 8'h04, 4);
		wr(OFS_RUN_TIME, 8'h01);
		wr(OFS_CMD, CMD_START);
		repeat (3) @(posedge CLK);
		rdchk(OFS_STATUS, {14'h0, 2'b01, ACC, ST_BUSY});
		rdchk(OFS_STATUS, {14'h0, 2'b10, ACC, ST_BUSY});
		// Accelerator state reads nonzero, so the host falls back to the longest window
		wr(OFS_RUN_TIME, 8'h0F);
		wr(OFS_CMD, CMD_CONTINUE);
		window(15);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_RESET});
		rdchk(OFS_COUNTS, 32'h0);
		wr(OFS_CMD, CMD_SELECT);
		rdchk(OFS_HDR_DATA, 32'h0);
		rdchk(OFS_PRD_DATA, 32'h0);
	endtask
	// Two input blocks: the first with the minimum run code, the last with its top bit set
	task automatic t_multi();
		wr(OFS_CMD, CMD_SELECT);
		send(8'h00, 8'h02, 2);
		rdchk(OFS_COUNTS, 32'h0208);
		wr(OFS_RUN_TIME, 8'h00);
		wr(OFS_CMD, CMD_START);
		window(0);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_RESET});
		wr(OFS_CMD, CMD_SELECT);
		send(8'h81, 8'h03, 3);
		rdchk(OFS_COUNTS, 32'h0308);
		wr(OFS_CMD, CMD_START);
		window(0);
		rdchk(OFS_STATUS, {16'h0, ACC, ST_RESET});
	endtask
	task automatic wrap_up();
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		t_reset();
		t_refuse();
		t_cmd();
		t_interrupt();
		t_multi();
		wrap_up();
	end
	// About 130 bus accesses and five windows, the longest 610 cycles, fit well inside this span
	initial begin
		repeat (20000) @(posedge CLK);
		err_count++;
		wrap_up();
	end
endmodule
